// ---- rtl/sdm_params.svh ----
// Timing counts, field positions, widths and command classes for the single-pin debug mode control block.
// Assumes inclusion by bare name from the package and modules; definitions only.
`ifndef SDM_PARAMS_SVH
`define SDM_PARAMS_SVH

// ******
// Security field and widths
// ******
`define SDM_SEC_W          2
`define SDM_SEC_UNSECURED  2'h2
`define SDM_PKT_W          8
`define SDM_BIT_CNT_W      3
`define SDM_BIT_LAST       3'h7
`define SDM_FIFO_DEPTH     8
`define SDM_CLS_MSB        7
`define SDM_CLS_LSB        4

// ******
// Serial timing, in serial debug clock ticks
// ******
`define SDM_TICK_W         8
`define SDM_SYNC_REQ_TICKS 8'h80
`define SDM_SYNC_RSP_TICKS 8'h80
`define SDM_SAMPLE_TICK    8'h0A
`define SDM_BIT_TICKS      8'h10
`define SDM_DRIVE_LOW_TICKS 8'h04
`define SDM_DRIVE_ONE_TICKS 8'h0D

// ******
// Command byte high-nibble classes
// ******
`define SDM_CLS_ALWAYS     4'h0
`define SDM_CLS_MEM        4'h1
`define SDM_CLS_DREG       4'h2
`define SDM_CLS_BKGND      4'h3
`define SDM_CLS_CPUREG     4'h4
`define SDM_CLS_STEP       4'h5
`define SDM_CLS_GO         4'h6
`define SDM_CLS_SECSTAT    4'h7
`define SDM_CLS_ERASE      4'h8

`endif

// ---- rtl/sdm_pkg.sv ----
// Types for the debug mode control block, which uses only sdm_ser_t; its packet FIFO uses none of them.
// Assumes sdm_params.svh is reachable on the include path.
`include "sdm_params.svh"
package sdm_pkg;
  // Serial engine states, Gray coded along the usual path
  typedef enum logic [2:0] {
    SDM_IDLE  = 3'b000,
    SDM_RXBIT = 3'b001,
    SDM_WAITH = 3'b011,
    SDM_SYNC  = 3'b010,
    SDM_TXBIT = 3'b110
  } sdm_ser_t;
  // Core run state encoding; the access filter takes coreHalted and coreStopped instead
  typedef enum logic [1:0] {
    SDM_RUN  = 2'b00,
    SDM_HALT = 2'b01,
    SDM_STOP = 2'b11
  } sdm_core_t;
endpackage : sdm_pkg

// ---- rtl/sdm_fifo_if.sv ----
// Valid/ready carrier between the debug control block and its packet FIFO.
// Assumes one clock shared by both ends.
`timescale 1ns/1ns
`default_nettype none
`include "sdm_params.svh"
interface sdm_fifo_if;
  logic                  inValid;  // Writer offers a packet
  logic                  inReady;  // FIFO can take it
  logic [`SDM_PKT_W-1:0] inData;   // Packet written
  logic                  outValid; // FIFO holds a packet
  logic                  outReady; // Reader takes it
  logic [`SDM_PKT_W-1:0] outData;  // Oldest packet
  modport fifo (input inValid, inData, outReady, output inReady, outValid, outData);
  modport user (output inValid, inData, outReady, input inReady, outValid, outData);
endinterface : sdm_fifo_if
`default_nettype wire

// ---- rtl/sdm_fifo.sv ----
// Parameterised synchronous FIFO carrying received debug packets.
// Assumes a single clock and synchronous active-high reset.
`timescale 1ns/1ns
`default_nettype none
module sdm_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  sdm_fifo_if.fifo port
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] memArr [DEPTH];  // Packet storage
  logic [AW-1:0]    wrPtr_reg;       // Write index
  logic [AW-1:0]    rdPtr_reg;       // Read index
  logic [AW:0]      count_reg;       // Occupancy
  logic             doWr;            // Accepted write
  logic             doRd;            // Accepted read

  assign port.inReady  = (count_reg != (AW+1)'(DEPTH));
  assign port.outValid = (count_reg != '0);
  assign port.outData  = memArr[rdPtr_reg];
  assign doWr = port.inValid && port.inReady;
  assign doRd = port.outValid && port.outReady;

  // Storage write
  always_ff @(posedge ref_clk) begin
    if (doWr) begin
      memArr[wrPtr_reg] <= port.inData;
    end
  end

  // Pointers and occupancy
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      wrPtr_reg <= '0;
      rdPtr_reg <= '0;
      count_reg <= '0;
    end else begin
      if (doWr) begin
        wrPtr_reg <= (wrPtr_reg == AW'(DEPTH-1)) ? '0 : wrPtr_reg + 1'b1;
      end
      if (doRd) begin
        rdPtr_reg <= (rdPtr_reg == AW'(DEPTH-1)) ? '0 : rdPtr_reg + 1'b1;
      end
      count_reg <= count_reg + (AW+1)'(doWr) - (AW+1)'(doRd);
    end
  end
endmodule : sdm_fifo
`default_nettype wire

// ---- rtl/sdm_mode_ctrl.sv ----
// Mode and access control for the single-pin debug controller, with a serial packet engine.
// Assumes core status, security field and control bits arrive synchronous to ref_clk.
//
// Summary of operation
// - Secured: only status report and erase
// - Interface disabled: status report only, erase only if secured
// - Unsecured and enabled: core state selects commands
// - Extended status top bytes always accessible
// - Non-intrusive commands need run or halt
// - Active commands need halt; register access stop
// - Low debug wire at power-on enters halt
// - Forced reset halts if wire low or bit
// - Background command wakes core then halts
// - Enabled halt instruction or breakpoint halts
// - Halted core fetches nothing, serves commands
// - Select bit: half CPU clock, else FLL
// - Enable gates halt, stop clocks, standby
// - Booting halted sets enable and select
// - Disabled halt instruction: reset or exception
// - Enabled interface restarts from stop/wait
// - Single wire, parties alternate driving
// - Sync request answered by timed pulse
// - Communication in eight-bit packets
`timescale 1ns/1ns
`default_nettype none
`include "sdm_params.svh"
module sdm_mode_ctrl (
  input  wire logic                   ref_clk,
  input  wire logic                   sys_rst,
  input  wire logic                   powerOnReset,       // Power-on reset phase
  input  wire logic                   forcedResetRelease, // Pulse: forced reset just ended
  input  wire logic [`SDM_SEC_W-1:0]  securityField,      // Nonvolatile security field
  input  wire logic                   fll_low_clock,      // FLL low clock, rising edge detected
  input  wire logic                   coreStopped,        // Core in stop or wait
  input  wire logic                   haltInstr,          // Pulse: halt instruction executed
  input  wire logic                   breakpointHalt,     // Pulse: breakpoint with halt response
  input  wire logic                   illegal_response_select,
  input  wire logic                   halt_after_forced_reset,
  input  wire logic                   enableWrite,        // Pulse: software writes enable bits
  input  wire logic                   enableWrData,       // Enable value written
  input  wire logic                   clkSelWrData,       // Clock select value written
  input  wire logic                   debug_wire_pin_in,  // Debug wire level
  output logic                        debug_wire_pin_out, // Debug wire drive value
  output logic                        debug_wire_pin_oe,  // High while driving the wire
  output logic                        debug_interface_enable,
  output logic                        debug_clock_select,
  output logic                        coreHalted,         // Core in halt mode
  output logic                        fetchEnable,        // Core may fetch instructions
  output logic                        wakeRequest,        // Wake core from stop/wait
  output logic                        stopClocksOn,       // Keep clocks running in stop
  output logic                        standbyAllow,       // Regulator may enter standby
  output logic                        illegalReset,       // Pulse: illegal halt gives reset
  output logic                        illegalException,   // Pulse: illegal halt gives exception
  output logic                        deviceSecured,      // Security state report
  output logic                        massEraseReq,       // Pulse: erase flash request
  output logic                        cmdAccepted,        // Pulse: command accepted
  output logic                        cmdRefused,         // Pulse: command refused
  output logic [`SDM_PKT_W-1:0]       cmdByte,            // Last command byte
  output logic                        xcsrAccess          // Pulse: always-available access
);
  // ******
  // Declarations
  // ******
  sdm_pkg::sdm_ser_t     ser_reg;        // Serial engine state
  logic                  pinSync1_reg;   // Synchroniser first stage
  logic                  pinSync2_reg;   // Synchroniser second stage
  logic                  fllSync1_reg;   // FLL clock first stage
  logic                  fllSync2_reg;   // FLL clock second stage
  logic                  fllLast_reg;    // FLL clock edge history
  logic                  halfDiv_reg;    // Half-rate divider
  logic                  serTick;        // Serial debug clock enable
  logic [`SDM_TICK_W-1:0] tick_reg;      // Ticks within a bit
  logic [`SDM_BIT_CNT_W-1:0] bit_reg;    // Bit index within a packet
  logic [`SDM_PKT_W-1:0] shift_reg;      // Receive shifter
  logic                  txWasLow_reg;   // Wire was driven low this slot
  logic                  bootSeen_reg;   // Power-on strap caught
  logic                  unlocked;       // Unsecured and enabled
  logic                  secured;        // Security field marks secured
  logic                  allowed;        // Command class allowed now
  logic [3:0]            cmdCls;         // Class nibble of the oldest packet
  sdm_fifo_if            fq ();          // Packet FIFO carrier

  // ******
  // Functions
  // ******
  // Decode: is the command class permitted in this state
  function automatic logic classAllowed(input logic [3:0] cls, input logic sec,
                                        input logic unl, input logic halted, input logic stopped);
    case (cls)
      `SDM_CLS_ALWAYS:  classAllowed = 1'b1;
      `SDM_CLS_SECSTAT: classAllowed = 1'b1;
      `SDM_CLS_ERASE:   classAllowed = sec;
      `SDM_CLS_MEM,
      `SDM_CLS_DREG:    classAllowed = unl && !stopped;
      `SDM_CLS_BKGND:   classAllowed = unl;
      `SDM_CLS_CPUREG:  classAllowed = unl && (halted || stopped);
      `SDM_CLS_STEP,
      `SDM_CLS_GO:      classAllowed = unl && halted;
      default:          classAllowed = 1'b0;
    endcase
  endfunction : classAllowed

  // ******
  // Access state
  // ******
  assign secured  = (securityField != `SDM_SEC_UNSECURED);
  assign unlocked = !secured && debug_interface_enable;
  assign cmdCls   = fq.outData[`SDM_CLS_MSB:`SDM_CLS_LSB];
  assign allowed  = classAllowed(cmdCls, secured, unlocked, coreHalted, coreStopped);

  // ******
  // Serial debug clock: half CPU or FLL low clock edge
  // ******
  // Divider and FLL edge detect produce the serial tick enable
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      halfDiv_reg  <= 1'b0;
      fllSync1_reg <= 1'b0;
      fllSync2_reg <= 1'b0;
      fllLast_reg  <= 1'b0;
    end else begin
      halfDiv_reg  <= !halfDiv_reg;
      fllSync1_reg <= fll_low_clock;
      fllSync2_reg <= fllSync1_reg;
      fllLast_reg  <= fllSync2_reg;
    end
  end
  assign serTick = debug_clock_select ? halfDiv_reg : (fllSync2_reg && !fllLast_reg);

  // Wire synchroniser, advanced on serial ticks only
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      pinSync1_reg <= 1'b1;
      pinSync2_reg <= 1'b1;
    end else if (serTick) begin
      pinSync1_reg <= debug_wire_pin_in;
      pinSync2_reg <= pinSync1_reg;
    end
  end

  // ******
  // Serial engine: receive packets and answer sync requests
  // ******
  // Host drives falling edge; a long low is a sync request
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      ser_reg            <= sdm_pkg::SDM_IDLE;
      tick_reg           <= '0;
      bit_reg            <= '0;
      shift_reg          <= '0;
      txWasLow_reg       <= 1'b0;
      debug_wire_pin_out <= 1'b1;
      debug_wire_pin_oe  <= 1'b0;
    end else if (serTick) begin
      case (ser_reg)
        sdm_pkg::SDM_IDLE: begin
          tick_reg <= '0;
          if (!pinSync2_reg) begin
            ser_reg <= sdm_pkg::SDM_RXBIT;
          end
        end
        sdm_pkg::SDM_RXBIT: begin
          tick_reg <= tick_reg + 1'b1;
          if (tick_reg == `SDM_SAMPLE_TICK) begin
            shift_reg <= {shift_reg[`SDM_PKT_W-2:0], pinSync2_reg};
          end
          if (!pinSync2_reg && tick_reg == `SDM_SYNC_REQ_TICKS) begin
            ser_reg <= sdm_pkg::SDM_WAITH;
          end else if (tick_reg >= `SDM_BIT_TICKS && pinSync2_reg) begin
            tick_reg <= '0;
            bit_reg  <= bit_reg + 1'b1;
            ser_reg  <= sdm_pkg::SDM_IDLE;
          end
        end
        sdm_pkg::SDM_WAITH: begin
          // Sync request: wait for host release then answer
          tick_reg <= '0;
          bit_reg  <= '0;
          if (pinSync2_reg) begin
            ser_reg <= sdm_pkg::SDM_SYNC;
          end
        end
        sdm_pkg::SDM_SYNC: begin
          // Timed low pulse, then drive high briefly and release
          tick_reg           <= tick_reg + 1'b1;
          debug_wire_pin_oe  <= 1'b1;
          debug_wire_pin_out <= (tick_reg >= `SDM_SYNC_RSP_TICKS);
          txWasLow_reg       <= 1'b1;
          if (tick_reg == `SDM_SYNC_RSP_TICKS) begin
            ser_reg <= sdm_pkg::SDM_TXBIT;
          end
        end
        sdm_pkg::SDM_TXBIT: begin
          // Speed-up high then release, handing the wire back
          debug_wire_pin_oe  <= 1'b0;
          debug_wire_pin_out <= 1'b1;
          txWasLow_reg       <= 1'b0;
          tick_reg           <= '0;
          ser_reg            <= sdm_pkg::SDM_IDLE;
        end
        default: begin
          ser_reg           <= sdm_pkg::SDM_IDLE;
          debug_wire_pin_oe <= 1'b0;
        end
      endcase
    end
  end

  // Packet write into the FIFO once eight bits are in
  assign fq.inValid  = serTick && (ser_reg == sdm_pkg::SDM_RXBIT) && pinSync2_reg &&
                       (tick_reg >= `SDM_BIT_TICKS) && (bit_reg == `SDM_BIT_LAST);
  assign fq.inData   = shift_reg;  // Eighth sample already shifted in
  assign fq.outReady = 1'b1;

  sdm_fifo #(
    .WIDTH (`SDM_PKT_W),
    .DEPTH (`SDM_FIFO_DEPTH)
  ) u_fifo (
    .ref_clk (ref_clk),
    .sys_rst (sys_rst),
    .port    (fq.fifo)
  );

  // ******
  // Command filter
  // ******
  // Classify each packet taken from the FIFO
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      cmdAccepted  <= 1'b0;
      cmdRefused   <= 1'b0;
      cmdByte      <= '0;
      xcsrAccess   <= 1'b0;
      massEraseReq <= 1'b0;
    end else begin
      cmdAccepted  <= fq.outValid && allowed;
      cmdRefused   <= fq.outValid && !allowed;
      xcsrAccess   <= fq.outValid && (cmdCls == `SDM_CLS_ALWAYS);
      massEraseReq <= fq.outValid && allowed && (cmdCls == `SDM_CLS_ERASE);
      if (fq.outValid) begin
        cmdByte <= fq.outData;
      end
    end
  end

  // ******
  // Halt mode and enable bits
  // ******
  // Power-on strap caught at the release of reset
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      bootSeen_reg           <= 1'b0;
      coreHalted             <= 1'b0;
      debug_interface_enable <= 1'b0;
      debug_clock_select     <= 1'b0;
      wakeRequest            <= 1'b0;
    end else begin
      wakeRequest <= 1'b0;
      if (!bootSeen_reg && !powerOnReset) begin
        bootSeen_reg <= 1'b1;
        if (!debug_wire_pin_in) begin
          coreHalted             <= 1'b1;
          debug_interface_enable <= 1'b1;
          debug_clock_select     <= 1'b1;
        end
      end else if (forcedResetRelease && (!debug_wire_pin_in || halt_after_forced_reset)) begin
        coreHalted             <= 1'b1;
        debug_interface_enable <= 1'b1;
        debug_clock_select     <= 1'b1;
      end else if (fq.outValid && allowed && cmdCls == `SDM_CLS_BKGND) begin
        coreHalted  <= 1'b1;
        wakeRequest <= coreStopped;
      end else if ((haltInstr || breakpointHalt) && debug_interface_enable) begin
        coreHalted <= 1'b1;
      end else if (fq.outValid && allowed && cmdCls == `SDM_CLS_GO) begin
        coreHalted <= 1'b0;
      end else if (enableWrite) begin
        debug_interface_enable <= enableWrData;
        debug_clock_select     <= clkSelWrData;
      end
    end
  end

  // Halted core stops fetching; enable governs low-power behaviour
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      fetchEnable   <= 1'b0;
      stopClocksOn  <= 1'b0;
      standbyAllow  <= 1'b1;
      deviceSecured <= 1'b1;
    end else begin
      fetchEnable   <= !coreHalted && bootSeen_reg;
      stopClocksOn  <= debug_interface_enable;
      standbyAllow  <= !debug_interface_enable;
      deviceSecured <= secured;
    end
  end

  // Halt instruction without enable is illegal
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      illegalReset     <= 1'b0;
      illegalException <= 1'b0;
    end else begin
      illegalReset     <= haltInstr && !debug_interface_enable && !illegal_response_select;
      illegalException <= haltInstr && !debug_interface_enable && illegal_response_select;
    end
  end
endmodule : sdm_mode_ctrl
`default_nettype wire

// ---- bench/sdm_mode_ctrl_properties.sv ----
// Concurrent checks on the debug mode control block's top-level ports.
// Assumes one clock domain and synchronous active-high reset; bound below.
`timescale 1ns/1ns
`default_nettype none
`include "sdm_params.svh"
module sdm_mode_ctrl_props (
  input wire logic                 ref_clk,
  input wire logic                 sys_rst,
  input wire logic                 powerOnReset,
  input wire logic                 forcedResetRelease,
  input wire logic [`SDM_SEC_W-1:0] securityField,
  input wire logic                 haltInstr,
  input wire logic                 breakpointHalt,
  input wire logic                 illegal_response_select,
  input wire logic                 halt_after_forced_reset,
  input wire logic                 debug_wire_pin_in,
  input wire logic                 debug_wire_pin_out,
  input wire logic                 debug_wire_pin_oe,
  input wire logic                 debug_interface_enable,
  input wire logic                 debug_clock_select,
  input wire logic                 coreHalted,
  input wire logic                 fetchEnable,
  input wire logic                 stopClocksOn,
  input wire logic                 standbyAllow,
  input wire logic                 illegalReset,
  input wire logic                 illegalException,
  input wire logic                 deviceSecured,
  input wire logic                 cmdAccepted,
  input wire logic [`SDM_PKT_W-1:0] cmdByte
);
  // ******
  // Mode, access and wire checks
  // ******
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  a_halt_enter: assert property ((haltInstr || breakpointHalt) && debug_interface_enable |=> coreHalted)
    else $error("halt request while enabled did not halt");
  a_illegal_halt: assert property (haltInstr && !debug_interface_enable |=>
    illegalReset == !$past(illegal_response_select) && illegalException == $past(illegal_response_select))
    else $error("disabled halt instruction gave wrong response");
  a_fetch_follow: assert property (!$past(sys_rst) |->
    fetchEnable == (!$past(coreHalted) && !$past(powerOnReset, 2) && !$past(sys_rst, 2)))
    else $error("fetch enable does not follow halt state");
  a_secure_report: assert property (!$past(sys_rst) |->
    deviceSecured == ($past(securityField) != `SDM_SEC_UNSECURED))
    else $error("security report mismatch");
  a_secure_filter: assert property (cmdAccepted && (deviceSecured || !$past(debug_interface_enable)) |->
    cmdByte[7:4] inside {`SDM_CLS_ALWAYS, `SDM_CLS_SECSTAT, `SDM_CLS_ERASE})
    else $error("restricted command accepted");
  a_answer_low: assert property ($rose(debug_wire_pin_oe) |-> !debug_wire_pin_out)
    else $error("wire drive does not start low");
  a_release_high: assert property ($fell(debug_wire_pin_oe) |-> $past(debug_wire_pin_out))
    else $error("wire released while driven low");
  a_enable_power: assert property ($stable(debug_interface_enable) |->
    standbyAllow == !debug_interface_enable && stopClocksOn == debug_interface_enable)
    else $error("stop clocks or standby disagree with enable");
  a_strap_boot: assert property ($fell(powerOnReset) && !debug_wire_pin_in |=>
    coreHalted && debug_interface_enable && debug_clock_select)
    else $error("low strap did not boot halted");
  a_forced_halt: assert property (forcedResetRelease && (!debug_wire_pin_in || halt_after_forced_reset)
    |=> coreHalted)
    else $error("forced reset did not halt");
  // Main scenarios reached
  c_sync_answer: cover property ($rose(debug_wire_pin_oe));
  c_illegal: cover property (illegalReset || illegalException);
  c_accept: cover property (cmdAccepted && coreHalted);
endmodule : sdm_mode_ctrl_props
bind sdm_mode_ctrl sdm_mode_ctrl_props sdm_mode_ctrl_props_inst (.ref_clk, .sys_rst, .powerOnReset,
  .forcedResetRelease, .securityField, .haltInstr, .breakpointHalt, .illegal_response_select,
  .halt_after_forced_reset, .debug_wire_pin_in, .debug_wire_pin_out, .debug_wire_pin_oe,
  .debug_interface_enable, .debug_clock_select, .coreHalted, .fetchEnable, .stopClocksOn,
  .standbyAllow, .illegalReset, .illegalException, .deviceSecured, .cmdAccepted, .cmdByte);
`default_nettype wire

// ---- bench/sdm_tool_model.sv ----
// Behavioural development tool on the single debug wire.
// Assumes an open-drain wire with a pull-up: the tool only ever pulls low.
`timescale 1ns/1ns
`default_nettype none
module sdm_tool_model (
  input  wire logic ref_clk,
  output var  logic toolLow  // High while the tool pulls the wire low
);
  // ******
  // Wire actions
  // ******
  initial toolLow = 1'b0;
  // Holds a level, used as boot and forced-reset strap
  task pin(input logic low);
    @(negedge ref_clk);
    toolLow = low;
  endtask : pin
  // Long low asks for a timed answer, then lets go so the device can drive
  task hold_low(input int n);
    @(negedge ref_clk);
    toolLow = 1'b1;
    repeat (n) @(negedge ref_clk);
    toolLow = 1'b0;
  endtask : hold_low
  // One packet, MSB first; short low is a one, long low a zero, 45 clocks a bit
  task send_byte(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      @(negedge ref_clk);
      toolLow = 1'b1;
      repeat (b[i] ? 8 : 30) @(negedge ref_clk);
      toolLow = 1'b0;
      repeat (b[i] ? 36 : 14) @(negedge ref_clk);
    end
  endtask : send_byte
endmodule : sdm_tool_model
`default_nettype wire

// ---- bench/test_sdm_mode_ctrl.sv ----
// Self-checking bench: drives modes, straps and serial packets, checks responses.
// Assumes the tool model only pulls the wire low and the wire idles high.
`timescale 1ns/1ns
`default_nettype none
`include "sdm_params.svh"
module test_sdm_mode_ctrl;
  // ******
  // Signals
  // ******
  logic ref_clk, sys_rst, powerOnReset, forcedResetRelease, coreStopped, haltInstr, breakpointHalt;
  logic fll_low_clock, illegal_response_select, halt_after_forced_reset, enableWrite, enableWrData;
  logic clkSelWrData, wireLevel, toolLow, clr, debug_wire_pin_out, debug_wire_pin_oe, coreHalted;
  logic debug_interface_enable, debug_clock_select, fetchEnable, wakeRequest, stopClocksOn, standbyAllow;
  logic illegalReset, illegalException, deviceSecured, massEraseReq, cmdAccepted, cmdRefused, xcsrAccess;
  logic [`SDM_SEC_W-1:0] securityField;
  logic [`SDM_PKT_W-1:0] cmdByte;
  logic [6:0]            seen;  // Sticky pulses: illRst illExc acc ref wake erase extended_control_status
  int                    n_errors, cmp_count;
  // Open-drain wire with pull-up
  assign wireLevel = !toolLow && !(debug_wire_pin_oe && !debug_wire_pin_out);
  initial begin ref_clk = 1'b0; forever #2 ref_clk = ~ref_clk; end
  initial begin fll_low_clock = 1'b0; #1; forever #24 fll_low_clock = ~fll_low_clock; end
  always @(posedge ref_clk) seen <= clr ? 7'h00 : seen | {illegalReset, illegalException, cmdAccepted,
    cmdRefused, wakeRequest, massEraseReq, xcsrAccess};
  sdm_mode_ctrl sdm_mode_ctrl_inst (.ref_clk, .sys_rst, .powerOnReset, .forcedResetRelease, .securityField,
    .fll_low_clock, .coreStopped, .haltInstr, .breakpointHalt, .illegal_response_select,
    .halt_after_forced_reset, .enableWrite, .enableWrData, .clkSelWrData, .debug_wire_pin_in(wireLevel),
    .debug_wire_pin_out, .debug_wire_pin_oe, .debug_interface_enable, .debug_clock_select, .coreHalted,
    .fetchEnable, .wakeRequest, .stopClocksOn, .standbyAllow, .illegalReset, .illegalException,
    .deviceSecured, .massEraseReq, .cmdAccepted, .cmdRefused, .cmdByte, .xcsrAccess);
  sdm_tool_model sdm_tool_model_inst (.ref_clk, .toolLow);
  // ******
  // Tasks
  // ******
  task tick(input int n); repeat (n) @(negedge ref_clk); endtask : tick
  task check(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  // Sends one packet, then checks the pulses seen and the halt state
  task cmd(input logic [7:0] b, input logic [6:0] e, input logic h);
    clr = 1'b1;
    tick(1);
    clr = 1'b0;
    sdm_tool_model_inst.send_byte(b);
    tick(20);
    check({9'h000, seen}, {9'h000, e});
    check({15'h0000, coreHalted}, {15'h0000, h});
    check({8'h00, cmdByte}, {8'h00, b});
  endtask : cmd
  // Sync request, then length of the device's answer in clock cycles
  task sync(input int lowCyc, input logic [15:0] expCyc);
    logic [15:0] n;
    n = 16'h0000;
    sdm_tool_model_inst.hold_low(lowCyc);
    for (int i = 0; i < 400 && !debug_wire_pin_oe; i++) tick(1);
    check({15'h0000, wireLevel}, 16'h0000);
    while (debug_wire_pin_oe && n < 16'h1000) begin tick(1); n++; end
    check(n, expCyc);
  endtask : sync
  task stop_test;
    if (n_errors == 0 && cmp_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : stop_test
  initial begin #120000; n_errors++; stop_test; end
  // ******
  // Sequence
  // ******
  initial begin
    sys_rst = 1'b1; powerOnReset = 1'b1; forcedResetRelease = 1'b0; coreStopped = 1'b0; haltInstr = 1'b0;
    breakpointHalt = 1'b0; illegal_response_select = 1'b0; halt_after_forced_reset = 1'b0; clr = 1'b0;
    enableWrite = 1'b0; enableWrData = 1'b0; clkSelWrData = 1'b0; securityField = 2'h2;
    n_errors = 0; cmp_count = 0;
    tick(3);
    check({12'h000, debug_wire_pin_out, standbyAllow, deviceSecured, coreHalted}, 16'h000E);
    sys_rst = 1'b0; tick(2); powerOnReset = 1'b0; tick(3);
    check({14'h0000, coreHalted, deviceSecured}, 16'h0000);
    sync(1700, 16'h060C);
    enableWrite = 1'b1; clkSelWrData = 1'b1; tick(1); enableWrite = 1'b0;
    sync(300, 16'h0102);
    cmd(8'h10, 7'h08, 1'b0);
    cmd(8'h00, 7'h11, 1'b0);
    for (int r = 0; r < 2; r++) begin
      illegal_response_select = r[0]; clr = 1'b1; tick(1); clr = 1'b0;
      haltInstr = 1'b1; tick(1); haltInstr = 1'b0; tick(2);
      check({9'h000, seen}, r ? 16'h0020 : 16'h0040);
    end
    enableWrite = 1'b1; enableWrData = 1'b1; tick(1); enableWrite = 1'b0; tick(2);
    check({14'h0000, standbyAllow, stopClocksOn}, 16'h0001);
    cmd(8'h10, 7'h10, 1'b0);
    cmd(8'h20, 7'h10, 1'b0);
    cmd(8'h40, 7'h08, 1'b0);
    for (int k = 0; k < 2; k++) begin
      haltInstr = !k[0]; breakpointHalt = k[0]; tick(1); haltInstr = 1'b0; breakpointHalt = 1'b0; tick(2);
      check({14'h0000, coreHalted, fetchEnable}, 16'h0002);
      cmd(8'h40, 7'h10, 1'b1);
      cmd(8'h50, 7'h10, 1'b1);
      cmd(8'h60, 7'h10, 1'b0);
    end
    check({15'h0000, fetchEnable}, 16'h0001);
    coreStopped = 1'b1;
    cmd(8'h40, 7'h10, 1'b0);
    cmd(8'h10, 7'h08, 1'b0);
    cmd(8'h30, 7'h14, 1'b1);
    coreStopped = 1'b0;
    cmd(8'h60, 7'h10, 1'b0);
    for (int k = 0; k < 2; k++) begin
      halt_after_forced_reset = !k[0]; sdm_tool_model_inst.pin(k[0]); tick(6);
      forcedResetRelease = 1'b1; tick(1); forcedResetRelease = 1'b0; tick(4);
      halt_after_forced_reset = 1'b0; sdm_tool_model_inst.pin(1'b0);
      check({15'h0000, coreHalted}, 16'h0001);
      sync(300, 16'h0102);
      cmd(8'h60, 7'h10, 1'b0);
    end
    sys_rst = 1'b1; powerOnReset = 1'b1; securityField = 2'h0; sdm_tool_model_inst.pin(1'b1); tick(3);
    sys_rst = 1'b0; tick(2); powerOnReset = 1'b0; tick(2); sdm_tool_model_inst.pin(1'b0); tick(2);
    check({13'h0000, coreHalted, debug_interface_enable, debug_clock_select}, 16'h0007);
    check({15'h0000, deviceSecured}, 16'h0001);
    sync(300, 16'h0102);
    cmd(8'h10, 7'h08, 1'b1);
    cmd(8'h00, 7'h11, 1'b1);
    cmd(8'h80, 7'h12, 1'b1);
    cmd(8'h70, 7'h10, 1'b1);
    stop_test;
  end
endmodule : test_sdm_mode_ctrl
`default_nettype wire
